// ===== pkg/ivpu_pkg.sv
// Shared constants and types for the interrupt vector and priority unit.
// Assumes one core clock and one system reset shared by both ends.
package ivpu_pkg;

	// ****************************************************************
	// Vector layout and priorities
	// ****************************************************************
	localparam int          PRIO_W         = 5;
	localparam int          VEC_COUNT      = 32;
	localparam int          MASKABLE_COUNT = 30;
	localparam logic [15:0] VEC_BASE       = 16'hFFC0;
	localparam logic [15:0] VEC_TOP        = 16'hFFFE;
	localparam int          VEC_SHIFT      = 1;
	localparam logic [4:0]  PRIO_RESET     = 5'h1F;
	localparam logic [4:0]  PRIO_NMI       = 5'h1E;

	typedef logic [PRIO_W-1:0] prio_t;
	typedef logic [15:0]       word_t;
	typedef logic [7:0]        byte_t;

	// ****************************************************************
	// Event sources
	// ****************************************************************
	// Reset class: power-on, pin reset, watchdog, key violation, fetch
	localparam int RESET_SRC_W   = 5;
	localparam int SRC_POWER_ON  = 0;
	// NMI class: pin edge, oscillator fault, flash access violation
	localparam int NMI_SRC_W     = 3;

	// ****************************************************************
	// Byte-wide special function registers
	// ****************************************************************
	localparam int    BYTE_BITS      = 8;
	localparam int    SFR_LANES      = 4;
	localparam byte_t SFR_MEN_BASE   = 8'h00;
	localparam byte_t SFR_MFLAG_BASE = 8'h04;
	localparam byte_t SFR_NMI_EN     = 8'h08;
	localparam byte_t SFR_NMI_FLAG   = 8'h09;
	localparam byte_t SFR_RST_FLAG   = 8'h0A;
	localparam logic [RESET_SRC_W-1:0] RST_FLAG_INIT = 5'h01;

	typedef logic [SFR_LANES*BYTE_BITS-1:0] lanes_t;

	// ****************************************************************
	// Core-side register port map
	// ****************************************************************
	localparam byte_t REG_SFR_LIMIT = 8'h40;
	localparam byte_t REG_PC        = 8'h80;
	localparam byte_t REG_SR        = 8'h82;
	localparam byte_t REG_INFO      = 8'h84;
	localparam byte_t REG_VEC_BASE  = 8'hC0;
	localparam int    GIE_BIT       = 3;

	// ****************************************************************
	// Timing, in core clock cycles
	// ****************************************************************
	localparam int LAT_BASIC  = 6;
	localparam int LAT_EXT    = 5;
	localparam int RET_BASIC  = 5;
	localparam int RET_EXT    = 3;
	localparam int STEP_PUSH_PC = 0;
	localparam int STEP_PUSH_SR = 1;
	localparam int STEP_CLR_SR  = 2;
	localparam int STEP_POP_SR  = 0;
	localparam int STEP_POP_PC  = 1;

endpackage

// ===== pkg/ivpu_if.sv
// Link between the interrupt unit and the processor core.
// Assumes both ends run on the same clk_sys and reset.
`timescale 1ns/1ps
interface ivpu_if;
	logic                 irqReq;
	ivpu_pkg::prio_t      irqIndex;
	ivpu_pkg::word_t      irqVector;
	logic                 irqAck;
	ivpu_pkg::prio_t      ackIndex;
	logic                 global_irq_enable;
	logic                 inHandler;
	ivpu_pkg::byte_t      sfrAddr;
	ivpu_pkg::byte_t      sfrWdata;
	logic                 sfrWr;
	logic                 sfrRd;
	ivpu_pkg::byte_t      sfrRdata;

	modport dev (
		output irqReq, irqIndex, irqVector, sfrRdata,
		input  irqAck, ackIndex, global_irq_enable, inHandler,
		input  sfrAddr, sfrWdata, sfrWr, sfrRd
	);
	modport cpu (
		input  irqReq, irqIndex, irqVector, sfrRdata,
		output irqAck, ackIndex, global_irq_enable, inHandler,
		output sfrAddr, sfrWdata, sfrWr, sfrRd
	);
endinterface

// ===== logic/irq_vector_unit.sv
// Interrupt vector and priority unit: flags, enables, arbitration.
// Assumes the core end acknowledges requests and reports its global
// enable over ivpu_if; all source inputs are on clk_sys.
`timescale 1ns/1ps
module irq_vector_unit #(
	parameter int NUM_MASKABLE = ivpu_pkg::MASKABLE_COUNT
) (
	input  wire logic                                 clk_sys,
	input  wire logic                                 reset,
	input  wire logic [ivpu_pkg::RESET_SRC_W-1:0]     resetSource,
	input  wire logic [ivpu_pkg::NMI_SRC_W-1:0]       nmiSource,
	input  wire logic [NUM_MASKABLE-1:0]              periphReq,
	output logic                                      irqOut,
	ivpu_if.dev                                       link
);
	import ivpu_pkg::*;

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	// Maskable sources only own the vectors below the NMI vector
	if (NUM_MASKABLE < 1 || NUM_MASKABLE > MASKABLE_COUNT ||
		NUM_MASKABLE > SFR_LANES * BYTE_BITS) begin : g_bad_count
		$error("NUM_MASKABLE out of range");
	end

	// ****************************************************************
	// Declarations
	// ****************************************************************
	wire  logic [NUM_MASKABLE-1:0]  enVec;
	wire  logic [NUM_MASKABLE-1:0]  flagVec;
	logic [NMI_SRC_W-1:0]           nmiEn;
	logic [NMI_SRC_W-1:0]           nmiFlag;
	logic [RESET_SRC_W-1:0]         resetFlag;
	logic                           resetPend;
	logic                           next_req;
	prio_t                          next_idx;
	byte_t                          rdata;
	lanes_t                         enPad;
	lanes_t                         flagPad;
	logic                           ackNmi;
	logic                           ackReset;
	logic                           wrNmiEn;
	logic                           wrNmiFlag;
	logic                           wrRstFlag;

	assign ackNmi    = link.irqAck && link.ackIndex == PRIO_NMI;
	assign ackReset  = link.irqAck && link.ackIndex == PRIO_RESET;
	assign wrNmiEn   = link.sfrWr && link.sfrAddr == SFR_NMI_EN;
	assign wrNmiFlag = link.sfrWr && link.sfrAddr == SFR_NMI_FLAG;
	assign wrRstFlag = link.sfrWr && link.sfrAddr == SFR_RST_FLAG;

	// ****************************************************************
	// Maskable flags and enables, one byte lane per eight sources
	// ****************************************************************
	for (genvar i = 0; i < NUM_MASKABLE; i++) begin : g_bit
		localparam byte_t LANE = byte_t'(i / BYTE_BITS);
		localparam int    POS  = i % BYTE_BITS;
		logic en;
		logic flag;
		logic wrEn;
		logic clr;

		// Byte writes only touch their own lane
		assign wrEn = link.sfrWr && link.sfrAddr == SFR_MEN_BASE + LANE;
		// Single-source flag clears on its own acknowledge or a one
		assign clr = (link.sfrWr && link.sfrAddr == SFR_MFLAG_BASE + LANE &&
			link.sfrWdata[POS]) ||
			(link.irqAck && link.ackIndex == prio_t'(i));

		always_ff @(posedge clk_sys or posedge reset) begin
			if (reset) begin
				en <= 1'b0;
			end else if (wrEn) begin
				en <= link.sfrWdata[POS];
			end
		end

		// A request landing in the clearing cycle is kept
		always_ff @(posedge clk_sys or posedge reset) begin
			if (reset) begin
				flag <= 1'b0;
			end else begin
				flag <= (flag & ~clr) | periphReq[i];
			end
		end

		assign enVec[i]   = en;
		assign flagVec[i] = flag;
	end

	// ****************************************************************
	// Non-maskable group
	// ****************************************************************
	// Accepting the NMI drops every NMI enable; software re-arms them
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			nmiEn <= '0;
		end else if (ackNmi) begin
			nmiEn <= '0;
		end else if (wrNmiEn) begin
			nmiEn <= link.sfrWdata[NMI_SRC_W-1:0];
		end
	end

	// Multi-source flags stay set for the handler to inspect
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			nmiFlag <= '0;
		end else if (wrNmiFlag) begin
			nmiFlag <= (nmiFlag & ~link.sfrWdata[NMI_SRC_W-1:0]) | nmiSource;
		end else begin
			nmiFlag <= nmiFlag | nmiSource;
		end
	end

	// ****************************************************************
	// Reset group
	// ****************************************************************
	// Power-up counts as a reset cause: the core starts from the top
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			resetFlag <= RST_FLAG_INIT;
		end else if (wrRstFlag) begin
			resetFlag <= (resetFlag & ~link.sfrWdata[RESET_SRC_W-1:0]) |
				resetSource;
		end else begin
			resetFlag <= resetFlag | resetSource;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			resetPend <= 1'b1;
		end else begin
			resetPend <= (resetPend & ~ackReset) | (|resetSource);
		end
	end

	// ****************************************************************
	// Arbitration
	// ****************************************************************
	// Ascending scan: the last hit is the highest vector address
	always_comb begin
		next_req = 1'b0;
		next_idx = '0;
		for (int i = 0; i < NUM_MASKABLE; i++) begin
			// No comparison with the running handler's level
			if (enVec[i] && flagVec[i] && link.global_irq_enable) begin
				next_req = 1'b1;
				next_idx = prio_t'(i);
			end
		end
		if (|(nmiFlag & nmiEn)) begin
			next_req = 1'b1;
			next_idx = PRIO_NMI;
		end
		if (resetPend) begin
			next_req = 1'b1;
			next_idx = PRIO_RESET;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			link.irqReq    <= 1'b0;
			link.irqIndex  <= '0;
			link.irqVector <= VEC_TOP;
		end else begin
			link.irqReq    <= next_req;
			link.irqIndex  <= next_idx;
			link.irqVector <= VEC_BASE +
				(word_t'(next_idx) << VEC_SHIFT);
		end
	end

	// Level summary of every enabled maskable and NMI flag, for an outside monitor
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			irqOut <= 1'b0;
		end else begin
			irqOut <= |(enVec & flagVec) || |(nmiFlag & nmiEn);
		end
	end

	// ****************************************************************
	// Register readback
	// ****************************************************************
	assign enPad   = lanes_t'(enVec);
	assign flagPad = lanes_t'(flagVec);

	// Unmapped bytes and unused bits read as zero
	always_comb begin
		rdata = '0;
		for (int k = 0; k < SFR_LANES; k++) begin
			if (link.sfrAddr == SFR_MEN_BASE + byte_t'(k)) begin
				rdata = enPad[k*BYTE_BITS +: BYTE_BITS];
			end
			if (link.sfrAddr == SFR_MFLAG_BASE + byte_t'(k)) begin
				rdata = flagPad[k*BYTE_BITS +: BYTE_BITS];
			end
		end
		if (link.sfrAddr == SFR_NMI_EN) begin
			rdata = byte_t'(nmiEn);
		end
		if (link.sfrAddr == SFR_NMI_FLAG) begin
			rdata = byte_t'(nmiFlag);
		end
		if (link.sfrAddr == SFR_RST_FLAG) begin
			rdata = byte_t'(resetFlag);
		end
	end

	assign link.sfrRdata = rdata;

endmodule // irq_vector_unit

// ===== logic/vector_fetch_core.sv
// Core end: accepts requests, stacks state, fetches vectors, returns.
// Assumes the interrupt unit on ivpu_if and a software register port.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
module vector_fetch_core #(
	parameter int LATENCY_CYCLES = ivpu_pkg::LAT_BASIC,
	parameter int RETURN_CYCLES  = ivpu_pkg::RET_BASIC,
	parameter int STACK_DEPTH    = 8
) (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire ivpu_pkg::byte_t   regAddr,
	input  wire ivpu_pkg::word_t   regWdata,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output ivpu_pkg::word_t        regRdata,
	input  wire logic              returnInstr,
	output ivpu_pkg::word_t        programCounter,
	output ivpu_pkg::word_t        statusWord,
	output logic                   handlerStart,
	ivpu_if.cpu                    link
);
	import ivpu_pkg::*;

	localparam int SPW = $clog2(STACK_DEPTH);

	if (!(LATENCY_CYCLES == LAT_BASIC || LATENCY_CYCLES == LAT_EXT) ||
		!(RETURN_CYCLES == RET_BASIC || RETURN_CYCLES == RET_EXT) ||
		STACK_DEPTH < 2 || (1 << SPW) != STACK_DEPTH) begin : g_bad_par
		$error("vector_fetch_core parameters not supported");
	end

	typedef enum {S_IDLE, S_ENTRY, S_RETURN} state_t;

	state_t          state;
	logic [3:0]      cnt;
	prio_t           takenIdx;
	logic [SPW-1:0]  sp;
	logic [SPW-1:0]  depth;
	word_t           stackMem [STACK_DEPTH];
	word_t           vecMem   [VEC_COUNT];
	logic            accept;
	logic            startRet;
	logic            isSfr;
	logic            isVec;
	logic            resetEntry;

	assign accept     = state == S_IDLE && link.irqReq;
	assign startRet   = state == S_IDLE && !link.irqReq && returnInstr &&
		depth != '0;
	assign isSfr      = regAddr < REG_SFR_LIMIT;
	assign isVec      = regAddr >= REG_VEC_BASE;
	assign resetEntry = takenIdx == PRIO_RESET;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= S_IDLE;
			cnt   <= '0;
		end else begin
			case (state)
				S_IDLE: begin
					cnt <= '0;
					if (accept) begin
						state <= S_ENTRY;
					end else if (startRet) begin
						state <= S_RETURN;
					end
				end
				S_ENTRY: begin
					cnt <= cnt + 4'h1;
					if (cnt == 4'(LATENCY_CYCLES - 1)) begin
						state <= S_IDLE;
					end
				end
				S_RETURN: begin
					cnt <= cnt + 4'h1;
					if (cnt == 4'(RETURN_CYCLES - 1)) begin
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			link.irqAck   <= 1'b0;
			link.ackIndex <= '0;
			takenIdx      <= '0;
		end else begin
			link.irqAck <= accept;
			if (accept) begin
				link.ackIndex <= link.irqIndex;
				takenIdx      <= link.irqIndex;
			end
		end
	end

	// ****************************************************************
	// Program counter, status word, stack pointer, nesting depth
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			programCounter <= '0;
			statusWord     <= '0;
			sp             <= '0;
			depth          <= '0;
			handlerStart   <= 1'b0;
		end else begin
			handlerStart <= 1'b0;
			case (state)
				S_IDLE: begin
					// Software sets the global enable here to allow nesting
					if (regWrite && regAddr == REG_SR) begin
						statusWord <= regWdata;
					end
					if (regWrite && regAddr == REG_PC) begin
						programCounter <= regWdata;
					end
				end
				S_ENTRY: begin
					// Reset class discards the stack instead of growing it
					if (!resetEntry && cnt == 4'(STEP_PUSH_PC)) begin
						sp <= sp + 1'b1;
					end
					if (!resetEntry && cnt == 4'(STEP_PUSH_SR)) begin
						sp <= sp + 1'b1;
					end
					if (cnt == 4'(STEP_CLR_SR)) begin
						statusWord <= '0;
					end
					if (cnt == 4'(LATENCY_CYCLES - 1)) begin
						programCounter <= vecMem[takenIdx];
						handlerStart   <= 1'b1;
						depth <= resetEntry ? '0 : depth + 1'b1;
						if (resetEntry) begin
							sp <= '0;
						end
					end
				end
				S_RETURN: begin
					if (cnt == 4'(STEP_POP_SR)) begin
						statusWord <= stackMem[sp - 1'b1];
						sp         <= sp - 1'b1;
					end
					if (cnt == 4'(STEP_POP_PC)) begin
						programCounter <= stackMem[sp - 1'b1];
						sp             <= sp - 1'b1;
					end
					if (cnt == 4'(RETURN_CYCLES - 1)) begin
						depth <= depth - 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	// Stack overflow wraps silently; software must bound nesting
	always_ff @(posedge clk_sys) begin
		if (state == S_ENTRY && !resetEntry) begin
			if (cnt == 4'(STEP_PUSH_PC)) begin
				stackMem[sp] <= programCounter;
			end
			if (cnt == 4'(STEP_PUSH_SR)) begin
				stackMem[sp] <= statusWord;
			end
		end
	end

	// Vector words are plain memory; unused ones may hold anything
	always_ff @(posedge clk_sys) begin
		if (regWrite && isVec) begin
			vecMem[regAddr[VEC_SHIFT +: PRIO_W]] <= regWdata;
		end
	end

	// ****************************************************************
	// Register port and link outputs
	// ****************************************************************
	// Only the low byte reaches the byte-wide registers
	assign link.sfrAddr   = regAddr;
	assign link.sfrWdata  = regWdata[BYTE_BITS-1:0];
	assign link.sfrWr     = regWrite && isSfr;
	assign link.sfrRd     = regRead && isSfr;
	assign link.global_irq_enable       = statusWord[GIE_BIT];
	assign link.inHandler = depth != '0;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			regRdata <= '0;
		end else if (regRead) begin
			if (isSfr) begin
				regRdata <= word_t'(link.sfrRdata);
			end else if (isVec) begin
				regRdata <= vecMem[regAddr[VEC_SHIFT +: PRIO_W]];
			end else if (regAddr == REG_PC) begin
				regRdata <= programCounter;
			end else if (regAddr == REG_SR) begin
				regRdata <= statusWord;
			end else if (regAddr == REG_INFO) begin
				regRdata <= word_t'({depth, state != S_IDLE});
			end else begin
				regRdata <= '0;
			end
		end else begin
			regRdata <= '0;
		end
	end

endmodule // vector_fetch_core

// ===== dv/ivpu_properties.sv
// Checker for the link between the interrupt unit and the core end.
// Assumes the ivpu_if signals on clk_sys with async active-high reset.
`timescale 1ns/1ps
module ivpu_properties (
	input  wire logic            clk_sys,
	input  wire logic            reset,
	input  wire logic            irqReq,
	input  wire ivpu_pkg::prio_t irqIndex,
	input  wire ivpu_pkg::word_t irqVector,
	input  wire logic            irqAck,
	input  wire ivpu_pkg::prio_t ackIndex,
	input  wire logic            global_irq_enable
);
	import ivpu_pkg::*;

	// ****************************************************************
	// Link properties
	// ****************************************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	AST_VEC_MAP: assert property (
		irqReq |-> irqVector == VEC_BASE + {10'h000, irqIndex, 1'b0})
		else $error("vector word differs from its index");
	AST_VEC_RANGE: assert property (
		irqReq |-> irqVector >= VEC_BASE && !irqVector[0])
		else $error("vector outside the aligned top region");
	// Request may land on the release edge or one later
	AST_RESET_FIRST: assert property (
		$past(reset) |-> ##[0:1] (irqReq && irqIndex == PRIO_RESET))
		else $error("no reset request after release");
	AST_ACK_PULSE: assert property (
		irqAck |=> !irqAck)
		else $error("acknowledge longer than one cycle");
	AST_ACK_CAUSE: assert property (
		$rose(irqAck) |-> $past(irqReq) && ackIndex == $past(irqIndex))
		else $error("acknowledge without matching request");
	AST_GIE_CLEAR: assert property (
		irqAck |-> ##[1:4] !global_irq_enable)
		else $error("global enable not cleared on entry");
	AST_MASK_GIE: assert property (
		irqReq && irqIndex < PRIO_NMI |-> $past(global_irq_enable))
		else $error("maskable request while global enable off");
	AST_NMI_VEC: assert property (
		irqReq && irqIndex == PRIO_NMI |-> irqVector == 16'hFFFC)
		else $error("non-maskable vector address wrong");
endmodule // ivpu_properties

// ===== dv/tb_interrupt_vector_priority_unit.sv
// Bench joining the interrupt unit and the core end across ivpu_if.
// Assumes one 10 MHz clk_sys and an async active-high reset.
`timescale 1ns/1ps
module tb_interrupt_vector_priority_unit;
	import ivpu_pkg::*;

	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic                      clk_sys;
	logic                      reset;
	logic [RESET_SRC_W-1:0]    resetSource;
	logic [NMI_SRC_W-1:0]      nmiSource;
	logic [MASKABLE_COUNT-1:0] periphReq;
	logic                      irqOut;
	byte_t                     regAddr;
	word_t                     regWdata;
	logic                      regWrite;
	logic                      regRead;
	word_t                     regRdata;
	logic                      returnInstr;
	word_t                     programCounter;
	word_t                     statusWord;
	logic                      handlerStart;
	int                        miscompares;
	int                        checked;
	word_t                     rd;

	ivpu_if ivpu_if_i ();
	irq_vector_unit irq_vector_unit_i (.clk_sys(clk_sys), .reset(reset),
		.resetSource(resetSource), .nmiSource(nmiSource),
		.periphReq(periphReq), .irqOut(irqOut), .link(ivpu_if_i));
	vector_fetch_core vector_fetch_core_i (.clk_sys(clk_sys),
		.reset(reset), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.returnInstr(returnInstr), .programCounter(programCounter),
		.statusWord(statusWord), .handlerStart(handlerStart),
		.link(ivpu_if_i));
	ivpu_properties ivpu_properties_i (.clk_sys(clk_sys), .reset(reset),
		.irqReq(ivpu_if_i.irqReq), .irqIndex(ivpu_if_i.irqIndex),
		.irqVector(ivpu_if_i.irqVector), .irqAck(ivpu_if_i.irqAck),
		.ackIndex(ivpu_if_i.ackIndex), .global_irq_enable(ivpu_if_i.global_irq_enable));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic word_t vec(input int i);
		return 16'h8000 + word_t'(i) * 16'h0100;
	endfunction

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic chkWord(input string what, input word_t e, input word_t g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask

	task automatic chkBit(input string what, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %b, seen %b", what, e, g);
		end
	endtask

	task automatic regWr(input byte_t a, input word_t d);
		@(posedge clk_sys);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask

	task automatic regRd(input byte_t a, output word_t d);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask

	task automatic pulse(input logic [MASKABLE_COUNT-1:0] p,
			input logic [NMI_SRC_W-1:0] n, input logic [RESET_SRC_W-1:0] r);
		@(posedge clk_sys);
		periphReq   <= p;
		nmiSource   <= n;
		resetSource <= r;
		@(posedge clk_sys);
		periphReq   <= '0;
		nmiSource   <= '0;
		resetSource <= '0;
	endtask

	// Latency is counted from the acknowledge to the first handler cycle.
	// Sampled mid-cycle: the acknowledge may rise on the edge the caller
	// returned on, and stands for that one cycle only.
	task automatic takeIrq(input word_t pc);
		int n;
		n = 0;
		@(negedge clk_sys);
		while (ivpu_if_i.irqAck !== 1'b1 && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
		chkBit("irqAck", 1'b1, ivpu_if_i.irqAck);
		n = 0;
		while (handlerStart !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		chkWord("latency", word_t'(LAT_BASIC), word_t'(n));
		chkWord("programCounter", pc, programCounter);
		chkWord("statusWord", 16'h0000, statusWord);
	endtask

	task automatic noAck(input int cycles);
		logic seen;
		seen = 1'b0;
		repeat (cycles) begin
			tick();
			if (ivpu_if_i.irqAck === 1'b1) seen = 1'b1;
		end
		chkBit("irqAck", 1'b0, seen);
	endtask

	task automatic retPulse();
		@(posedge clk_sys);
		returnInstr <= 1'b1;
		@(posedge clk_sys);
		returnInstr <= 1'b0;
	endtask

	task automatic retCheck(input word_t pc, input word_t sr);
		retPulse();
		repeat (RET_BASIC + 1) tick();
		chkWord("programCounter", pc, programCounter);
		chkWord("statusWord", sr, statusWord);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Vector 31 must be written before the reset entry fetches it
	task automatic t_boot();
		reset <= 1'b0;
		regWr(8'hFE, vec(31));
		takeIrq(vec(31));
		for (int i = 0; i < 31; i++) regWr(byte_t'(8'hC0 + 2 * i), vec(i));
		regRd(8'hC0, rd);
		chkWord("vector0", vec(0), rd);
		regRd(8'h86, rd);
		chkWord("unmapped", 16'h0000, rd);
		$display("test boot done");
	endtask

	task automatic t_mask();
		pulse(30'h00000004, 3'h0, 5'h00);
		tick();
		chkBit("irqOut", 1'b0, irqOut);
		regRd(8'h04, rd);
		chkWord("flags0", 16'h0004, rd);
		regWr(8'h00, 16'h0004);
		tick();
		tick();
		chkBit("irqOut", 1'b1, irqOut);
		noAck(8);
		regWr(8'h04, 16'h0004);
		tick();
		tick();
		chkBit("irqOut", 1'b0, irqOut);
		regRd(8'h04, rd);
		chkWord("flags0", 16'h0000, rd);
		$display("test mask done");
	endtask

	task automatic t_prio();
		regWr(8'h00, 16'h00FF);
		regWr(8'h01, 16'h00FF);
		pulse(30'h00001020, 3'h0, 5'h00);
		noAck(8);
		regWr(8'h82, 16'h0008);
		takeIrq(vec(12));
		retPulse();
		takeIrq(vec(5));
		retCheck(vec(31), 16'h0008);
		$display("test priority done");
	endtask

	task automatic t_nest();
		regWr(8'h02, 16'h0010);
		pulse(30'h00100000, 3'h0, 5'h00);
		takeIrq(vec(20));
		pulse(30'h00000008, 3'h0, 5'h00);
		noAck(8);
		regWr(8'h82, 16'h0008);
		takeIrq(vec(3));
		chkBit("inHandler", 1'b1, ivpu_if_i.inHandler);
		regRd(8'h84, rd);
		chkWord("info", 16'h0004, rd);
		retCheck(vec(20), 16'h0008);
		retCheck(vec(31), 16'h0008);
		$display("test nesting done");
	endtask

	task automatic t_nmi();
		regWr(8'h82, 16'h0000);
		regWr(8'h08, 16'h0001);
		pulse(30'h00000000, 3'h1, 5'h00);
		takeIrq(vec(30));
		regRd(8'h08, rd);
		chkWord("nmiEnable", 16'h0000, rd);
		regRd(8'h09, rd);
		chkWord("nmiFlags", 16'h0001, rd);
		regWr(8'h09, 16'h0001);
		regRd(8'h09, rd);
		chkWord("nmiFlags", 16'h0000, rd);
		retCheck(vec(31), 16'h0000);
		$display("test nmi done");
	endtask

	task automatic t_wdog();
		pulse(30'h00000000, 3'h0, 5'h04);
		takeIrq(vec(31));
		regRd(8'h0A, rd);
		chkWord("resetFlags", 16'h0004, rd & 16'h0004);
		$display("test watchdog done");
	endtask

	task automatic results();
		$display("checks %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// Clock, sequence and watchdog
	// ****************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	initial begin
		miscompares = 0;
		checked     = 0;
		reset       = 1'b1;
		resetSource = '0;
		nmiSource   = '0;
		periphReq   = '0;
		regAddr     = 8'h00;
		regWdata    = 16'h0000;
		regWrite    = 1'b0;
		regRead     = 1'b0;
		returnInstr = 1'b0;
		repeat (16) @(posedge clk_sys);
		t_boot();
		t_mask();
		t_prio();
		t_nest();
		t_nmi();
		t_wdog();
		results();
	end

	// The tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		miscompares++;
		results();
	end
endmodule // tb_interrupt_vector_priority_unit
